/* src/display_control_pkg.sv */
// constants for the display control unit: register map, fields, reset values, cycle codes
package display_control_pkg;

    // ************************************************************
    // register indices on the plain register port
    // ************************************************************
    localparam logic [1:0] ADDR_DISPLAY_CONTROL   = 2'h0;
    localparam logic [1:0] ADDR_REFRESH_START     = 2'h1;
    localparam logic [1:0] ADDR_REFRESH_ADDRESS   = 2'h2;
    localparam logic [1:0] ADDR_STATUS            = 2'h3;

    // ************************************************************
    // display_control field positions
    // ************************************************************
    localparam int HSYNC_DIRECTION_BIT         = 0;
    localparam int RESERVED_BIT                = 1;
    localparam int STEP_LSB                    = 2;
    localparam int STEP_MSB                    = 9;
    localparam int ORIGIN_SELECT_BIT           = 10;
    localparam int TRANSFER_CONVERT_BIT        = 11;
    localparam int AUTO_REFRESH_BIT            = 12;
    localparam int INTERNAL_TIMING_BIT         = 13;
    localparam int NONINTERLACE_BIT            = 14;
    localparam int VIDEO_ENABLE_BIT            = 15;
    localparam logic [15:0] CONTROL_WRITE_MASK = 16'hFFFD;

    // refresh_start / refresh_address layout: line count in [1:0], address in [15:2]
    localparam int LINE_COUNT_MSB              = 1;
    localparam int ADDRESS_LSB                 = 2;
    localparam int DIP_STATUS_BIT              = 0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] CONTROL_RESET      = 16'h0000;
    localparam logic [15:0] START_RESET        = 16'h0000;
    localparam logic [13:0] ADDRESS_RESET      = 14'h0000;
    localparam logic [1:0]  LINE_COUNT_RESET   = 2'h0;
    localparam logic [2:0]  SYNC_PIPE_RESET    = 3'h7;

    // ************************************************************
    // memory cycle kinds for pixel and other accesses
    // ************************************************************
    typedef enum logic [1:0] {
        CYC_NORMAL_READ  = 2'b00,
        CYC_NORMAL_WRITE = 2'b01,
        CYC_MEM_TO_REG   = 2'b10,
        CYC_REG_TO_MEM   = 2'b11
    } cycle_kind_e;

endpackage : display_control_pkg

/* src/display_control_unit.sv */
// display control unit: control register, sync direction, refresh addressing, blanking
//
// Behaviour
// - hsync_direction and internal_timing_select set sync pin directions; both set: outputs.
// - hsync input: external hsync start or h count at total starts horizontal sync, whichever first; hsync output: h total only.
// - both inputs: vsync on ext vsync, v total with ext hsync, or both totals.
// - vsync input, hsync output: vsync on ext vsync or both counters at total.
// - step field is one-hot, value 1..128, zero means no step.
// - after each refresh cycle add step, or subtract it when origin_select set.
// - interlaced: before even field reload from start register, then step by half.
// - origin_select 0 puts origin upper left, 1 lower left.
// - transfer convert turns pixel reads/writes into register transfer cycles.
// - instruction fetches and non-pixel accesses are never converted.
// - auto_refresh_enable issues refresh cycles in selected horizontal blanking intervals.
// - refresh enable change takes effect at next blanking start, first refresh there.
// - internal_timing_select 0 locks to external sync, 1 generates own timing.
// - noninterlace_select 0 gives interlaced timing, 1 noninterlaced.
// - video enable 0 forces blanking low and inhibits setting display_int_pending.
// - display_int_pending already set stays set until software clears it.
// - video enable 1 passes timing blanking and sets pending on interrupt line match.
// - refresh address field is output as logical address bits 10 to 23.
// - start_line_count code n spaces refreshes every n+1 lines.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module display_control_unit (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // register port
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // video timing events from the counters and compare registers
    input  wire logic        h_at_total_i,
    input  wire logic        v_at_total_i,
    input  wire logic        hsync_end_i,
    input  wire logic        vsync_end_i,
    input  wire logic        hblank_start_i,
    input  wire logic        vblank_start_i,
    input  wire logic        even_field_next_i,
    input  wire logic        timing_blank_n_i,
    input  wire logic        v_at_interrupt_line_i,
    // sync pins, active low; sync start strobes and display status
    input  wire logic        hsync_n_i,
    output logic             hsync_n_o,
    output logic             hsync_oe_n_o,
    input  wire logic        vsync_n_i,
    output logic             vsync_n_o,
    output logic             vsync_oe_n_o,
    output logic             hsync_start_o,
    output logic             vsync_start_o,
    output logic             interlace_o,
    output logic             blank_n_o,
    output logic             display_int_pending_o,
    // automatic refresh cycles
    output logic             refresh_req_o,
    output logic      [13:0] refresh_addr_o,
    input  wire logic        refresh_done_i,
    // processor memory accesses
    input  wire logic        mem_req_i,
    input  wire logic        mem_write_i,
    input  wire logic        mem_pixel_i,
    output logic             cyc_valid_o,
    output logic      [1:0]  cyc_kind_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [15:0] ctl;
        logic [15:0] start;
        logic [13:0] refresh_address_field;
        logic [1:0]  lncnt;
        logic        sre_eff;
        logic        display_int_pending;
        logic [15:0] rdata;
        logic [2:0]  hs_pipe;
        logic [2:0]  vs_pipe;
        logic        hs_f;
        logic        vs_f;
        logic        hs_act;
        logic        vs_act;
        logic        hs_start;
        logic        vs_start;
        logic        hs_oe_n;
        logic        vs_oe_n;
        logic        interlace;
        logic        blank_n;
        logic        ref_req;
        logic        ref_busy;
        logic [13:0] ref_addr;
        logic        cyc_valid;
        logic [1:0]  cyc_kind;
    } state_s;

    state_s s_q;
    state_s s_d;

    // one-hot field is already the binary step size
    function automatic logic [13:0] step_of(input logic [15:0] ctl);
        step_of = {6'h00, ctl[display_control_pkg::STEP_MSB:display_control_pkg::STEP_LSB]};
    endfunction : step_of

    function automatic logic [13:0] move(input logic [13:0] a, input logic [13:0] st,
                                         input logic down);
        move = down ? a - st : a + st;
    endfunction : move

    logic hsync_direction;
    logic internal_timing_select;
    logic h_in;
    logic v_in;
    logic ext_h_start;
    logic ext_v_start;
    logic [13:0] step;

    assign hsync_direction  = s_q.ctl[display_control_pkg::HSYNC_DIRECTION_BIT];
    assign internal_timing_select  = s_q.ctl[display_control_pkg::INTERNAL_TIMING_BIT];
    assign h_in = !hsync_direction && !internal_timing_select;
    assign v_in = !internal_timing_select;
    assign step = step_of(s_q.ctl);

    always_comb begin
        s_d = s_q;
        s_d.hs_start  = 1'b0;
        s_d.vs_start  = 1'b0;
        s_d.ref_req   = 1'b0;
        s_d.cyc_valid = 1'b0;
        ext_h_start   = 1'b0;
        ext_v_start   = 1'b0;

        // ************************************************************
        // register port
        // ************************************************************
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                display_control_pkg::ADDR_DISPLAY_CONTROL:
                    s_d.ctl = reg_wdata_i & display_control_pkg::CONTROL_WRITE_MASK;
                display_control_pkg::ADDR_REFRESH_START: s_d.start = reg_wdata_i;
                display_control_pkg::ADDR_REFRESH_ADDRESS: begin
                    s_d.refresh_address_field = reg_wdata_i[15:display_control_pkg::ADDRESS_LSB];
                    s_d.lncnt  = reg_wdata_i[display_control_pkg::LINE_COUNT_MSB:0];
                end
                display_control_pkg::ADDR_STATUS:
                    if (reg_wdata_i[display_control_pkg::DIP_STATUS_BIT]) begin
                        s_d.display_int_pending = 1'b0;
                    end
            endcase
        end
        s_d.rdata = 16'h0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                display_control_pkg::ADDR_DISPLAY_CONTROL: s_d.rdata = s_q.ctl;
                display_control_pkg::ADDR_REFRESH_START:   s_d.rdata = s_q.start;
                display_control_pkg::ADDR_REFRESH_ADDRESS: s_d.rdata = {s_q.refresh_address_field, s_q.lncnt};
                display_control_pkg::ADDR_STATUS:          s_d.rdata = {15'h0000, s_q.display_int_pending};
            endcase
        end

        // ************************************************************
        // sync pin inputs: a level counts once the last two stages agree
        // ************************************************************
        s_d.hs_pipe = {s_q.hs_pipe[1:0], hsync_n_i};
        s_d.vs_pipe = {s_q.vs_pipe[1:0], vsync_n_i};
        if (s_q.hs_pipe[1] == s_q.hs_pipe[2]) begin
            s_d.hs_f    = s_q.hs_pipe[2];
            ext_h_start = s_q.hs_f && !s_q.hs_pipe[2];
        end
        if (s_q.vs_pipe[1] == s_q.vs_pipe[2]) begin
            s_d.vs_f    = s_q.vs_pipe[2];
            ext_v_start = s_q.vs_f && !s_q.vs_pipe[2];
        end

        // ************************************************************
        // sync intervals and pin directions
        // ************************************************************
        s_d.hs_oe_n   = h_in;
        s_d.vs_oe_n   = v_in;
        s_d.interlace = !s_q.ctl[display_control_pkg::NONINTERLACE_BIT];
        if (hsync_end_i) begin
            s_d.hs_act = 1'b0;
        end
        if (!s_q.hs_act && ((h_in && ext_h_start) || h_at_total_i)) begin
            s_d.hs_act   = 1'b1;
            s_d.hs_start = 1'b1;
        end
        if (vsync_end_i) begin
            s_d.vs_act = 1'b0;
        end
        if (!s_q.vs_act) begin
            if ((v_in && ext_v_start) || (v_at_total_i && h_at_total_i)
                || (h_in && v_at_total_i && ext_h_start)) begin
                s_d.vs_act   = 1'b1;
                s_d.vs_start = 1'b1;
            end
        end

        // ************************************************************
        // blanking and display interrupt
        // ************************************************************
        s_d.blank_n = s_q.ctl[display_control_pkg::VIDEO_ENABLE_BIT] && timing_blank_n_i;
        if (s_q.ctl[display_control_pkg::VIDEO_ENABLE_BIT] && v_at_interrupt_line_i) begin
            s_d.display_int_pending = 1'b1; // set wins over a same-cycle clear
        end

        // ************************************************************
        // screen refresh
        // ************************************************************
        if (refresh_done_i && s_q.ref_busy) begin
            s_d.ref_busy = 1'b0;
            s_d.refresh_address_field   = move(s_q.refresh_address_field, step,
                                s_q.ctl[display_control_pkg::ORIGIN_SELECT_BIT]);
            s_d.lncnt    = s_q.start[display_control_pkg::LINE_COUNT_MSB:0];
        end
        if (hblank_start_i) begin
            s_d.sre_eff = s_q.ctl[display_control_pkg::AUTO_REFRESH_BIT];
            if (s_q.ctl[display_control_pkg::AUTO_REFRESH_BIT] && !s_q.ref_busy) begin
                if (!s_q.sre_eff || s_q.lncnt == 2'h0) begin
                    s_d.ref_req  = 1'b1;
                    s_d.ref_busy = 1'b1;
                    s_d.ref_addr = s_q.refresh_address_field;
                end else begin
                    s_d.lncnt = s_q.lncnt - 2'h1;
                end
            end
        end
        // frame reload has the last word over the address
        if (vblank_start_i) begin
            s_d.lncnt  = s_q.start[display_control_pkg::LINE_COUNT_MSB:0];
            s_d.refresh_address_field = s_q.start[15:display_control_pkg::ADDRESS_LSB];
            if (s_d.interlace && even_field_next_i) begin
                s_d.refresh_address_field = move(s_q.start[15:display_control_pkg::ADDRESS_LSB], step >> 1,
                                  s_q.ctl[display_control_pkg::ORIGIN_SELECT_BIT]);
            end
        end

        // ************************************************************
        // processor access conversion
        // ************************************************************
        if (mem_req_i) begin
            s_d.cyc_valid = 1'b1;
            if (mem_pixel_i && s_q.ctl[display_control_pkg::TRANSFER_CONVERT_BIT]) begin
                s_d.cyc_kind = mem_write_i ? display_control_pkg::CYC_REG_TO_MEM
                                           : display_control_pkg::CYC_MEM_TO_REG;
            end else begin
                s_d.cyc_kind = mem_write_i ? display_control_pkg::CYC_NORMAL_WRITE
                                           : display_control_pkg::CYC_NORMAL_READ;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s_q          <= '0;
            s_q.ctl      <= display_control_pkg::CONTROL_RESET;
            s_q.start    <= display_control_pkg::START_RESET;
            s_q.refresh_address_field   <= display_control_pkg::ADDRESS_RESET;
            s_q.lncnt    <= display_control_pkg::LINE_COUNT_RESET;
            s_q.hs_pipe  <= display_control_pkg::SYNC_PIPE_RESET;
            s_q.vs_pipe  <= display_control_pkg::SYNC_PIPE_RESET;
            s_q.hs_f     <= 1'b1;
            s_q.vs_f     <= 1'b1;
            s_q.hs_oe_n  <= 1'b1;
            s_q.vs_oe_n  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata_o           = s_q.rdata;
    assign hsync_n_o             = !s_q.hs_act;
    assign hsync_oe_n_o          = s_q.hs_oe_n;
    assign vsync_n_o             = !s_q.vs_act;
    assign vsync_oe_n_o          = s_q.vs_oe_n;
    assign hsync_start_o         = s_q.hs_start;
    assign vsync_start_o         = s_q.vs_start;
    assign interlace_o           = s_q.interlace;
    assign blank_n_o             = s_q.blank_n;
    assign display_int_pending_o = s_q.display_int_pending;
    assign refresh_req_o         = s_q.ref_req;
    assign refresh_addr_o        = s_q.ref_addr;
    assign cyc_valid_o           = s_q.cyc_valid;
    assign cyc_kind_o            = s_q.cyc_kind;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    pin_direction_a: assert property (
        ##1 (hsync_oe_n_o == $past(h_in)) && (vsync_oe_n_o == $past(v_in)))
        else $error("sync pin direction does not follow control bits");

    hsync_start_a: assert property (
        (!s_q.hs_act && h_at_total_i) |=> hsync_start_o && !hsync_n_o)
        else $error("horizontal sync did not start at total");

    vsync_totals_a: assert property (
        (!s_q.vs_act && v_at_total_i && h_at_total_i) |=> vsync_start_o)
        else $error("vertical sync did not start at both totals");

    vsync_internal_a: assert property (
        (internal_timing_select && !(v_at_total_i && h_at_total_i)) |=> !vsync_start_o)
        else $error("vertical sync started without counter cause");

    refresh_step_a: assert property (
        (refresh_done_i && s_q.ref_busy && !vblank_start_i && !reg_wr_i)
        |=> s_q.refresh_address_field == move($past(s_q.refresh_address_field), $past(step),
                               $past(s_q.ctl[display_control_pkg::ORIGIN_SELECT_BIT])))
        else $error("refresh address not stepped by programmed amount");

    pixel_convert_a: assert property (
        (mem_req_i && !mem_pixel_i) |=> cyc_valid_o && !cyc_kind_o[1])
        else $error("non-pixel access was converted");

    refresh_off_a: assert property (
        (!s_q.ctl[display_control_pkg::AUTO_REFRESH_BIT]) |=> !refresh_req_o)
        else $error("refresh issued while disabled");

    blank_forced_a: assert property (
        !s_q.ctl[display_control_pkg::VIDEO_ENABLE_BIT] [*2] |=> !blank_n_o)
        else $error("blanking not forced with video disabled");

    dip_hold_a: assert property (
        (s_q.display_int_pending && !(reg_wr_i && reg_addr_i == display_control_pkg::ADDR_STATUS))
        |=> display_int_pending_o)
        else $error("pending flag dropped without software clear");

    reserved_zero_a: assert property (
        s_q.ctl[display_control_pkg::RESERVED_BIT] == 1'b0)
        else $error("reserved control bit is set");

endmodule : display_control_unit

/* sim/video_partner.sv */
// partner model: sync source on the pins and vram answering refresh cycles
`timescale 1ns/1ps

module video_partner (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    // sync source levels and device side of the pins, active low
    input  wire logic       ext_hsync_n_i,
    input  wire logic       ext_vsync_n_i,
    input  wire logic       hsync_n_i,
    input  wire logic       hsync_oe_n_i,
    input  wire logic       vsync_n_i,
    input  wire logic       vsync_oe_n_i,
    output logic            hsync_pin_n_o,
    output logic            vsync_pin_n_o,
    // refresh handshake
    input  wire logic [3:0] delay_i,
    input  wire logic       refresh_req_i,
    output logic            refresh_done_o
);
    logic [3:0] wait_q;

    // pin level: device output while it drives, else the sync source
    assign hsync_pin_n_o = hsync_oe_n_i ? ext_hsync_n_i : hsync_n_i;
    assign vsync_pin_n_o = vsync_oe_n_i ? ext_vsync_n_i : vsync_n_i;

    // delay_i sets a prompt or a slow vram
    always_ff @(posedge mclk_i) begin
        refresh_done_o <= 1'b0;
        if (sys_rst_i) begin
            wait_q <= 4'h0;
        end else if (refresh_req_i) begin
            wait_q <= delay_i;
        end else if (wait_q != 4'h0) begin
            wait_q         <= wait_q - 4'h1;
            refresh_done_o <= (wait_q == 4'h1);
        end
    end
endmodule : video_partner

/* sim/tb_top.sv */
// testbench of the display control unit
`timescale 1ns/1ps

module tb_top;
    logic        mclk_i, sys_rst_i, reg_wr, reg_rd, even_next, tblank_n, ext_h, ext_v, done;
    logic        mem_req, mem_write, mem_pixel, hs_n, hs_oe_n, vs_n, vs_oe_n, hs_pin, vs_pin;
    logic        hs_start, vs_start, interlace, blank_n, pend, req, cyc_valid;
    logic [1:0]  reg_addr, cyc_kind;
    logic [3:0]  delay;
    logic [6:0]  ev_q;
    logic [13:0] raddr;
    logic [15:0] reg_wdata, rdata, d;
    int          errors, comparisons;

    display_control_unit display_control_unit_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .h_at_total_i(ev_q[0]), .v_at_total_i(ev_q[1]), .hsync_end_i(ev_q[2]),
        .vsync_end_i(ev_q[3]), .hblank_start_i(ev_q[4]), .vblank_start_i(ev_q[5]),
        .even_field_next_i(even_next), .timing_blank_n_i(tblank_n),
        .v_at_interrupt_line_i(ev_q[6]), .hsync_n_i(hs_pin), .hsync_n_o(hs_n),
        .hsync_oe_n_o(hs_oe_n), .vsync_n_i(vs_pin), .vsync_n_o(vs_n), .vsync_oe_n_o(vs_oe_n),
        .hsync_start_o(hs_start), .vsync_start_o(vs_start), .interlace_o(interlace),
        .blank_n_o(blank_n), .display_int_pending_o(pend), .refresh_req_o(req),
        .refresh_addr_o(raddr), .refresh_done_i(done), .mem_req_i(mem_req),
        .mem_write_i(mem_write), .mem_pixel_i(mem_pixel), .cyc_valid_o(cyc_valid),
        .cyc_kind_o(cyc_kind));

    video_partner video_partner_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ext_hsync_n_i(ext_h), .ext_vsync_n_i(ext_v),
        .hsync_n_i(hs_n), .hsync_oe_n_i(hs_oe_n), .vsync_n_i(vs_n), .vsync_oe_n_i(vs_oe_n),
        .hsync_pin_n_o(hs_pin), .vsync_pin_n_o(vs_pin), .delay_i(delay),
        .refresh_req_i(req), .refresh_done_o(done));

    // ************************************************************
    // clock, checks and bus tasks
    // ************************************************************
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge mclk_i);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk_i);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a);
        @(posedge mclk_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk_i);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    // one-cycle timing events; returns inside the answer cycle
    task automatic pulse(input logic [6:0] m);
        @(posedge mclk_i);
        ev_q <= m;
        @(posedge mclk_i);
        ev_q <= 7'h00;
        #1;
    endtask : pulse

    // bounded wait on a flag, checked afterwards by the caller
    task automatic wait_hi(input int sel);
        repeat (20) begin
            @(posedge mclk_i);
            #1;
            if ((sel == 0 ? hs_start : sel == 1 ? vs_start : done) === 1'b1) break;
        end
    endtask : wait_hi

    task automatic refresh(input logic [15:0] ctl, input logic [13:0] a, input logic [15:0] nxt);
        wr(2'h0, ctl);
        pulse(7'h20);
        pulse(7'h10);
        chk({refresh_req_o_w(), raddr}, {1'b1, a});
        wait_hi(2);
        rd(2'h2);
        chk(d, nxt);
    endtask : refresh

    function automatic logic refresh_req_o_w();
        return req;
    endfunction : refresh_req_o_w

    task automatic stop_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (5000) @(posedge mclk_i);
        errors++;
        stop_test;
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        {reg_wr, reg_rd, mem_req, mem_write, mem_pixel, even_next} = 6'h00;
        {reg_addr, reg_wdata, ev_q} = '0;
        {ext_h, ext_v, tblank_n, sys_rst_i} = 4'hF;
        delay = 4'h1;
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rd(2'h0);
        chk(d, display_control_pkg::CONTROL_RESET);
        chk({blank_n, hs_oe_n, vs_oe_n, interlace}, 4'h7);
        wr(2'h0, 16'hFFFF);
        rd(2'h0);
        chk(d, 16'hFFFD);
        for (int i = 0; i < 3; i++) begin
            wr(2'h0, {2'h0, i[1], 12'h000, i[0]});
            repeat (2) @(posedge mclk_i);
            #1;
            chk({hs_oe_n, vs_oe_n}, {~(i[0] | i[1]), ~i[1]});
        end
        wr(2'h0, 16'h4000);
        repeat (2) @(posedge mclk_i);
        #1;
        chk(interlace, 1'b0);
        wr(2'h0, 16'h0000);
        pulse(7'h01);
        chk({hs_start, hs_n}, 2'b10);
        pulse(7'h04);
        ext_h <= 1'b0;
        wait_hi(0);
        chk(hs_start, 1'b1);
        ext_h <= 1'b1;
        pulse(7'h04);
        pulse(7'h03);
        chk({vs_start, vs_n}, 2'b10);
        pulse(7'h0C);
        wr(2'h0, 16'h0001);
        pulse(7'h02);
        chk(vs_start, 1'b0);
        ext_v <= 1'b0;
        wait_hi(1);
        chk({vs_start, vs_n}, 2'b10);
        ext_v <= 1'b1;
        pulse(7'h0C);
        wr(2'h1, 16'h0400);
        refresh(16'h5010, 14'h0100, 16'h0410);
        delay <= 4'h6;
        refresh(16'h5410, 14'h0100, 16'h03F0);
        wr(2'h1, 16'h0401);
        pulse(7'h20);
        pulse(7'h10);
        chk(req, 1'b0);
        pulse(7'h10);
        chk(req, 1'b1);
        wait_hi(2);
        wr(2'h0, 16'h4010);
        pulse(7'h10);
        chk(req, 1'b0);
        wr(2'h1, 16'h0400);
        wr(2'h0, 16'h1020);
        even_next <= 1'b1;
        pulse(7'h20);
        rd(2'h2);
        chk(d, 16'h0410);
        wr(2'h0, 16'h0000);
        pulse(7'h40);
        chk({blank_n, pend}, 2'b00);
        wr(2'h0, 16'h8000);
        pulse(7'h40);
        chk({blank_n, pend}, 2'b11);
        wr(2'h0, 16'h0000);
        rd(2'h3);
        chk({d[14:0], pend}, 16'h0003);
        wr(2'h3, 16'h0001);
        rd(2'h3);
        chk(d, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(2'h0, {4'h0, i[2], 11'h000});
            @(posedge mclk_i);
            mem_req   <= 1'b1;
            mem_write <= i[0];
            mem_pixel <= i[1];
            @(posedge mclk_i);
            mem_req <= 1'b0;
            #1;
            chk({cyc_valid, cyc_kind}, {1'b1, i[2] & i[1], i[0]});
        end
        stop_test;
    end
endmodule : tb_top
